//--- core/amp_input_filter.sv
// Two-flop synchroniser and optional glitch filter for sensor pins
`timescale 1ns/10ps
module amp_input_filter #(
  parameter int WIDTH = 5,
  parameter int STABLE_CYC = 160
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic enable,
  // Pins and cleaned levels
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] clean
);
  localparam int CNT_W = $clog2(STABLE_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYC - 1);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [CNT_W-1:0] cnt_q [WIDTH];

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    meta_q <= pins;
    sync_q <= meta_q;
  end

  // A change must hold for the whole window before it passes
  always_ff @(posedge clk) begin
    for (int i = 0; i < WIDTH; i++) begin
      if (srst) begin
        cnt_q[i] <= '0;
        clean[i] <= 1'b0;
      end else if (!enable || sync_q[i] == clean[i]) begin
        cnt_q[i] <= '0;
        if (!enable) clean[i] <= sync_q[i];
      end else if (cnt_q[i] == CNT_LAST) begin
        cnt_q[i] <= '0;
        clean[i] <= sync_q[i];
      end else begin
        cnt_q[i] <= cnt_q[i] + 1'b1;
      end
    end
  end
endmodule

//--- core/amp_param_regs.sv
// Per-axis motion parameter registers with APB access and terminal setup
// Behaviour
// - Centre/feed value is taken only while kind code is 62h to 65h.
// - Kinds 62h and 63h read it as master-axis incremental feed.
// - Kinds 64h and 65h read it as incremental circle centre.
// - Centre/feed is signed 28-bit; software keeps it in range.
// - Sign-extension bits ignore writes and read as the top stored bit.
// - Unused bits ignore writes and read as zero.
// - Acceleration S range holds bits 14..0; software writes 1 to 32767.
// - Deceleration S range holds bits 14..0; software writes 1 to 32767.
// - A zero S range is replaced by half of high minus low speed.
// - Correction speed drives correction moves and home-return reverse.
// - Correction speed is 16 bits and is scaled by the speed scale.
// - Centre/feed and both S ranges each have a working copy used.
// - Environment word is 32 bits; low three bits choose pulse format.
// - Formats 000/001 drive direction high for plus; 010/011 invert.
// - With the filter bit set, sensor pulses under 4 us are ignored.
// - Wipe mode: 00 fall, 01 rise, 10 low level, 11 high level.
// - Shared start trigger: 0 level, 1 edge.
// - Half duty bit gives equal pulse high and low times.
`timescale 1ns/10ps
module amp_param_regs #(
  parameter int FILTER_CYC = amp_pkg::FILTER_CYC,
  parameter int PULSE_W = amp_pkg::PULSE_W_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [amp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Motion engine side, same clock
  input wire logic motionStart,
  input wire logic moveMinus,
  input wire logic stepTick,
  input wire logic correctionMove,
  input wire logic homeReverse,
  // Pins from outside
  input wire logic [amp_pkg::SENSOR_N-1:0] sensorPins,
  input wire logic counterWipeLine,
  input wire logic sharedStartLine_n,
  // Working values to the motion engine
  output logic [amp_pkg::CENTER_W-1:0] centerFeedWork,
  output logic interpUsesCenter,
  output logic centerIsFeed,
  output logic centerIsCircle,
  output logic [amp_pkg::SRANGE_W-1:0] sAccelEff,
  output logic [amp_pkg::SRANGE_W-1:0] sDecelEff,
  output logic [31:0] constSpeedRate,
  // Terminal outputs
  output logic [amp_pkg::SENSOR_N-1:0] sensorsClean,
  output logic counterWipe,
  output logic sharedStartFire,
  output logic pulseOut,
  output logic dirOut
);
  localparam int CW = amp_pkg::CENTER_W;
  localparam int SW = amp_pkg::SRANGE_W;
  localparam int VW = amp_pkg::SPEED_W;
  localparam int KW = amp_pkg::KIND_W;

  // Readable offsets; anything else answers with an error
  function automatic logic isMapped(input logic [amp_pkg::ADDR_W-1:0] a);
    return a == amp_pkg::OFF_CENTER || a == amp_pkg::OFF_SACC ||
      a == amp_pkg::OFF_SDEC || a == amp_pkg::OFF_CORR ||
      a == amp_pkg::OFF_ENV1 || a == amp_pkg::OFF_OPMODE ||
      a == amp_pkg::OFF_FH || a == amp_pkg::OFF_FL ||
      a == amp_pkg::OFF_SCALE || a == amp_pkg::OFF_WCENTER ||
      a == amp_pkg::OFF_WSACC || a == amp_pkg::OFF_WSDEC ||
      a == amp_pkg::OFF_STATUS;
  endfunction

  // Signed field read back with its sign copied into the upper bits
  function automatic logic [31:0] signExt(input logic [CW-1:0] v);
    return {{(32 - CW){v[CW-1]}}, v};
  endfunction

  // Zero range falls back to half the speed span; reversed span gives zero
  function automatic logic [SW-1:0] sRangeEff(input logic [SW-1:0] work,
      input logic [VW-1:0] fh, input logic [VW-1:0] fl);
    logic [VW-1:0] span;
    span = (fh > fl) ? (fh - fl) : '0;
    return (work != '0) ? work : span[VW-1:1];
  endfunction

  // Speed register times magnification, full width so nothing is lost
  function automatic logic [31:0] scaleSpeed(input logic [VW-1:0] s,
      input logic [VW-1:0] m);
    return s * m;
  endfunction

  // Kind codes that use the centre/feed value
  function automatic logic kindIsInterp(input logic [KW-1:0] k);
    return k == amp_pkg::KIND_CLIN2 || k == amp_pkg::KIND_LIN2 ||
      k == amp_pkg::KIND_CW || k == amp_pkg::KIND_CCW;
  endfunction

  // Pre-registers and plain registers
  logic [CW-1:0] centerPre_q;
  logic [SW-1:0] sAccPre_q;
  logic [SW-1:0] sDecPre_q;
  logic [VW-1:0] corr_q;
  logic [31:0] env1_q;
  logic [KW-1:0] opKind_q;
  logic [VW-1:0] highSpeed_q;
  logic [VW-1:0] lowSpeed_q;
  logic [VW-1:0] scale_q;
  // Working copies
  logic [CW-1:0] centerWork_q;
  logic [SW-1:0] sAccWork_q;
  logic [SW-1:0] sDecWork_q;
  // Bus state
  logic [31:0] readWord;
  logic accessGo;
  logic wrEn;
  // Pin synchronisers and edge history
  logic [1:0] wipeSync_q;
  logic wipeLast_q;
  logic [1:0] startSync_q;
  logic startLast_q;
  amp_pkg::amp_wipe_type wipeMode;
  logic wipeHit;
  logic startLow;
  logic startHit;
  logic kindValid;
  logic [31:0] statusWord;

  // One wait state: ready rises in the second access cycle
  assign accessGo = psel & penable & pready;
  assign wrEn = accessGo & pwrite;
  assign kindValid = kindIsInterp(opKind_q);

  // Status word shows live block state
  assign statusWord = {{(32 - amp_pkg::SENSOR_N - 3){1'b0}}, sensorsClean,
    interpUsesCenter, centerIsCircle, centerIsFeed};

  // Read view per offset; unused bits zero, signed field extended
  always_comb begin
    unique case (paddr)
      amp_pkg::OFF_CENTER: readWord = signExt(centerPre_q);
      amp_pkg::OFF_SACC: readWord = {{(32 - SW){1'b0}}, sAccPre_q};
      amp_pkg::OFF_SDEC: readWord = {{(32 - SW){1'b0}}, sDecPre_q};
      amp_pkg::OFF_CORR: readWord = {{(32 - VW){1'b0}}, corr_q};
      amp_pkg::OFF_ENV1: readWord = env1_q;
      amp_pkg::OFF_OPMODE: readWord = {{(32 - KW){1'b0}}, opKind_q};
      amp_pkg::OFF_FH: readWord = {{(32 - VW){1'b0}}, highSpeed_q};
      amp_pkg::OFF_FL: readWord = {{(32 - VW){1'b0}}, lowSpeed_q};
      amp_pkg::OFF_SCALE: readWord = {{(32 - VW){1'b0}}, scale_q};
      amp_pkg::OFF_WCENTER: readWord = signExt(centerWork_q);
      amp_pkg::OFF_WSACC: readWord = {{(32 - SW){1'b0}}, sAccWork_q};
      amp_pkg::OFF_WSDEC: readWord = {{(32 - SW){1'b0}}, sDecWork_q};
      amp_pkg::OFF_STATUS: readWord = statusWord;
      default: readWord = '0;
    endcase
  end

  // APB handshake and registered answer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~isMapped(paddr);
      if (psel & penable & ~pready & ~pwrite) prdata <= readWord;
    end
  end

  // Software writes; only implemented bits are stored
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      centerPre_q <= '0;
      sAccPre_q <= '0;
      sDecPre_q <= '0;
      corr_q <= '0;
      env1_q <= amp_pkg::ENV1_RESET;
      opKind_q <= '0;
      highSpeed_q <= '0;
      lowSpeed_q <= '0;
      scale_q <= '0;
    end else if (wrEn) begin
      unique case (paddr)
        amp_pkg::OFF_CENTER: centerPre_q <= pwdata[CW-1:0];
        amp_pkg::OFF_SACC: sAccPre_q <= pwdata[SW-1:0];
        amp_pkg::OFF_SDEC: sDecPre_q <= pwdata[SW-1:0];
        amp_pkg::OFF_CORR: corr_q <= pwdata[VW-1:0];
        amp_pkg::OFF_ENV1: env1_q <= pwdata;
        amp_pkg::OFF_OPMODE: opKind_q <= pwdata[KW-1:0];
        amp_pkg::OFF_FH: highSpeed_q <= pwdata[VW-1:0];
        amp_pkg::OFF_FL: lowSpeed_q <= pwdata[VW-1:0];
        amp_pkg::OFF_SCALE: scale_q <= pwdata[VW-1:0];
        default: ;
      endcase
    end
  end

  // Command start copies pre-registers so the next move can be preloaded
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      centerWork_q <= '0;
      sAccWork_q <= '0;
      sDecWork_q <= '0;
      interpUsesCenter <= 1'b0;
      centerIsFeed <= 1'b0;
      centerIsCircle <= 1'b0;
    end else if (motionStart) begin
      sAccWork_q <= sAccPre_q;
      sDecWork_q <= sDecPre_q;
      if (kindValid) centerWork_q <= centerPre_q;
      interpUsesCenter <= kindValid;
      centerIsFeed <= opKind_q == amp_pkg::KIND_CLIN2 ||
        opKind_q == amp_pkg::KIND_LIN2;
      centerIsCircle <= opKind_q == amp_pkg::KIND_CW ||
        opKind_q == amp_pkg::KIND_CCW;
    end
  end

  // Values handed to the motion engine, all registered
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      centerFeedWork <= '0;
      sAccelEff <= '0;
      sDecelEff <= '0;
      constSpeedRate <= amp_pkg::REG_RESET;
    end else begin
      centerFeedWork <= centerWork_q;
      sAccelEff <= sRangeEff(sAccWork_q, highSpeed_q, lowSpeed_q);
      sDecelEff <= sRangeEff(sDecWork_q, highSpeed_q, lowSpeed_q);
      constSpeedRate <= (correctionMove | homeReverse) ?
        scaleSpeed(corr_q, scale_q) : scaleSpeed(lowSpeed_q, scale_q);
    end
  end

  // Sensor filter on limit, slowdown, home, alarm and in-position
  amp_input_filter #(
    .WIDTH(amp_pkg::SENSOR_N),
    .STABLE_CYC(FILTER_CYC)
  ) u_filter (
    .clk(ref_clk),
    .srst(srst),
    .enable(env1_q[amp_pkg::ENV_SENSOR_NOISE_FILTER]),
    .pins(sensorPins),
    .clean(sensorsClean)
  );

  // Wipe and start pins cross in through two flops each
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wipeSync_q <= '0;
      wipeLast_q <= 1'b0;
      startSync_q <= 2'h3;
      startLast_q <= 1'b1;
    end else begin
      wipeSync_q <= {wipeSync_q[0], counterWipeLine};
      wipeLast_q <= wipeSync_q[1];
      startSync_q <= {startSync_q[0], sharedStartLine_n};
      startLast_q <= startSync_q[1];
    end
  end

  // Counter wipe by edge or level as configured
  assign wipeMode = amp_pkg::amp_wipe_type'(env1_q[amp_pkg::ENV_CLR_LSB +: 2]);
  always_comb begin
    unique case (wipeMode)
      amp_pkg::WIPE_FALL: wipeHit = wipeLast_q & ~wipeSync_q[1];
      amp_pkg::WIPE_RISE: wipeHit = ~wipeLast_q & wipeSync_q[1];
      amp_pkg::WIPE_LOW: wipeHit = ~wipeSync_q[1];
      amp_pkg::WIPE_HIGH: wipeHit = wipeSync_q[1];
    endcase
  end

  // Shared start is active low; edge mode fires once per falling edge
  assign startLow = ~startSync_q[1];
  assign startHit = env1_q[amp_pkg::ENV_SHARED_START_TRIGGER_TYPE] ?
    (startLast_q & startLow) : startLow;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      counterWipe <= 1'b0;
      sharedStartFire <= 1'b0;
    end else begin
      counterWipe <= wipeHit;
      sharedStartFire <= startHit;
    end
  end

  // Pulse shaping in its own module
  amp_pulse_if pif ();
  assign pif.tick = stepTick;
  assign pif.minus = moveMinus;
  assign pif.fmt = env1_q[amp_pkg::ENV_FMT_LSB +: amp_pkg::FMT_W];
  assign pif.halfDuty = env1_q[amp_pkg::ENV_HALF_DUTY_PULSE];

  amp_pulse_shaper #(
    .PULSE_W(PULSE_W)
  ) u_shaper (
    .clk(ref_clk),
    .srst(srst),
    .pif(pif)
  );

  // Shaper outputs are flops already
  assign pulseOut = pif.pulseOut;
  assign dirOut = pif.dirOut;
endmodule

//--- core/amp_pulse_shaper.sv
// Output pulse and direction line shaping for the selected pulse format
`timescale 1ns/10ps
module amp_pulse_shaper #(
  parameter int PULSE_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pulse request and output lines
  amp_pulse_if.shaper pif
);
  localparam int W_W = $clog2(PULSE_W + 1);
  localparam logic [W_W-1:0] W_LOAD = W_W'(PULSE_W);

  logic [W_W-1:0] width_q;
  logic level_q;
  logic active;
  logic outNext;
  logic dirNext;

  // Fixed-width pulse per tick, or a toggle per tick for equal high/low
  always_ff @(posedge clk) begin
    if (srst) begin
      width_q <= '0;
      level_q <= 1'b0;
    end else if (pif.tick) begin
      width_q <= W_LOAD;
      if (pif.halfDuty) level_q <= ~level_q;
    end else if (width_q != '0) begin
      width_q <= width_q - 1'b1;
    end
  end

  assign active = pif.halfDuty ? level_q : (width_q != '0);
  // Single-line formats carry direction on one pin; two-line split the pulse
  assign outNext = pif.fmt[2] ? (active & ~pif.minus) : (active ^ pif.fmt[0]);
  assign dirNext = pif.fmt[2] ? (active & pif.minus) : (~pif.minus ^ pif.fmt[1]);

  // Registered outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      pif.pulseOut <= 1'b0;
      pif.dirOut <= 1'b0;
    end else begin
      pif.pulseOut <= outNext;
      pif.dirOut <= dirNext;
    end
  end
endmodule

//--- pkg/amp_pkg.sv
// Constants and types shared by the axis motion parameter register block
package amp_pkg;
  // APB register offsets (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CENTER = 8'h00;
  localparam logic [7:0] OFF_SACC = 8'h04;
  localparam logic [7:0] OFF_SDEC = 8'h08;
  localparam logic [7:0] OFF_CORR = 8'h0c;
  localparam logic [7:0] OFF_ENV1 = 8'h10;
  localparam logic [7:0] OFF_OPMODE = 8'h14;
  localparam logic [7:0] OFF_FH = 8'h18;
  localparam logic [7:0] OFF_FL = 8'h1c;
  localparam logic [7:0] OFF_SCALE = 8'h20;
  localparam logic [7:0] OFF_WCENTER = 8'h24;
  localparam logic [7:0] OFF_WSACC = 8'h28;
  localparam logic [7:0] OFF_WSDEC = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  // Field widths
  localparam int CENTER_W = 28;
  localparam int SRANGE_W = 15;
  localparam int SPEED_W = 16;
  localparam int KIND_W = 7;
  localparam int FMT_W = 3;
  localparam int SENSOR_N = 5;
  // Operation kind codes that use the centre/feed value
  localparam logic [6:0] KIND_CLIN2 = 7'h62;
  localparam logic [6:0] KIND_LIN2 = 7'h63;
  localparam logic [6:0] KIND_CW = 7'h64;
  localparam logic [6:0] KIND_CCW = 7'h65;
  // Environment 1 field positions and reset value
  localparam int ENV_FMT_LSB = 0;
  localparam int ENV_SHARED_START_TRIGGER_TYPE = 18;
  localparam int ENV_CLR_LSB = 20;
  localparam int ENV_SENSOR_NOISE_FILTER = 26;
  localparam int ENV_HALF_DUTY_PULSE = 31;
  localparam logic [31:0] ENV1_RESET = 32'h0;
  localparam logic [31:0] REG_RESET = 32'h0;
  // Sensor filter timing at the 40 MHz reference clock
  localparam int CLK_MHZ = 40;
  localparam int FILTER_NS = 4000;
  localparam int FILTER_CYC = (FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_W_CYC = 4;
  // Counter wipe input modes, codes 00 to 11 in order
  typedef enum logic [1:0] {WIPE_FALL, WIPE_RISE, WIPE_LOW, WIPE_HIGH} amp_wipe_type;
endpackage

//--- pkg/amp_pulse_if.sv
// Carrier between the register block and its pulse output shaper
`timescale 1ns/10ps
interface amp_pulse_if;
  logic tick;
  logic minus;
  logic [2:0] fmt;
  logic halfDuty;
  logic pulseOut;
  logic dirOut;
  modport ctrl (output tick, minus, fmt, halfDuty, input pulseOut, dirOut);
  modport shaper (input tick, minus, fmt, halfDuty, output pulseOut, dirOut);
endinterface

//--- verif/amp_host_model.sv
// Host processor model issuing APB transfers to the parameter block
`timescale 1ns/10ps
module amp_host_model (
  // Clock
  input wire logic clk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer; the request stands until pready is sampled high at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer and read data are taken at the very edge that sees pready high
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Released bus shows no stale data
  endtask
endmodule

//--- verif/amp_param_regs_assertions.sv
// Concurrent checks on the APB port and working centre output of the parameter block
`timescale 1ns/10ps
module amp_param_regs_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [amp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Motion side
  input wire logic motionStart,
  input wire logic [amp_pkg::CENTER_W-1:0] centerFeedWork
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Reads of the data ports at the completing cycle
  wire rdDone = pready && !pwrite;
  wire rangeAddr = paddr == 8'h04 || paddr == 8'h08 || paddr == 8'h28 || paddr == 8'h2c;

  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside second access cycle");
  access_answer_a: assert property (psel && $rose(penable) |=> pready)
    else $error("no answer one cycle after access start");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_error_a: assert property (pready && paddr > 8'h30 |-> pslverr)
    else $error("unmapped access not refused");
  mapped_no_error_a: assert property (pready && paddr <= 8'h30 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  refused_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  center_sign_ext_a: assert property (rdDone && (paddr == 8'h00 || paddr == 8'h24) |->
    prdata[31:28] == {4{prdata[27]}})
    else $error("centre read not sign extended");
  range_top_zero_a: assert property (rdDone && rangeAddr |->
    prdata[31:15] == 17'h0)
    else $error("S range unused bits not zero");
  corr_top_zero_a: assert property (rdDone && paddr == 8'h0c |->
    prdata[31:16] == 16'h0)
    else $error("correction speed unused bits not zero");
  work_on_start_a: assert property ($changed(centerFeedWork) |->
    $past(motionStart, 2))
    else $error("working centre changed without a start");

  // Main scenarios
  cover property (pready && pwrite && !pslverr);
  cover property (pready && !pwrite && pslverr);
  cover property (motionStart ##2 $changed(centerFeedWork));
endmodule

bind amp_param_regs amp_param_regs_assertions amp_param_regs_assertions_i (
  .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .motionStart(motionStart), .centerFeedWork(centerFeedWork));

//--- verif/axis_motion_param_registers_bench.sv
// Self-checking bench for the axis motion parameter register block
`timescale 1ns/10ps
module axis_motion_param_registers_bench;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic motionStart = 1'b0;
  logic moveMinus = 1'b0;
  logic stepTick = 1'b0;
  logic correctionMove = 1'b0;
  logic homeReverse = 1'b0;
  logic [4:0] sensorPins = 5'h00;
  logic counterWipeLine = 1'b0;
  logic sharedStartLine_n = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, interpUsesCenter, centerIsFeed;
  logic centerIsCircle, counterWipe, sharedStartFire, pulseOut, dirOut, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, constSpeedRate, rd, v;
  logic [27:0] centerFeedWork;
  logic [14:0] sAccelEff, sDecelEff;
  logic [4:0] sensorsClean;
  logic [7:0] regAddr [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
  logic [6:0] kinds [5] = '{amp_pkg::KIND_CLIN2, amp_pkg::KIND_LIN2, amp_pkg::KIND_CW,
                            amp_pkg::KIND_CCW, 7'h00};
  int failures = 0;
  int samples_checked = 0;
  int mdl [int]; // Model of written register words
  int unsigned rnd;

  always #12.5 ref_clk = ~ref_clk;

  amp_param_regs #(.FILTER_CYC(4), .PULSE_W(4)) amp_param_regs_i (.ref_clk(ref_clk),
    .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motionStart(motionStart), .moveMinus(moveMinus), .stepTick(stepTick),
    .correctionMove(correctionMove), .homeReverse(homeReverse), .sensorPins(sensorPins),
    .counterWipeLine(counterWipeLine), .sharedStartLine_n(sharedStartLine_n),
    .centerFeedWork(centerFeedWork), .interpUsesCenter(interpUsesCenter),
    .centerIsFeed(centerIsFeed), .centerIsCircle(centerIsCircle), .sAccelEff(sAccelEff),
    .sDecelEff(sDecelEff), .constSpeedRate(constSpeedRate), .sensorsClean(sensorsClean),
    .counterWipe(counterWipe), .sharedStartFire(sharedStartFire), .pulseOut(pulseOut),
    .dirOut(dirOut));
  amp_host_model amp_host_model_i (.clk(ref_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // Read view of a stored word: sign extension and unused bits applied
  function automatic logic [31:0] view(input logic [7:0] a, input logic [31:0] w);
    case (a)
      8'h00: return {{4{w[27]}}, w[27:0]};
      8'h04, 8'h08: return {17'h0, w[14:0]};
      8'h0c, 8'h20: return {16'h0, w[15:0]};
      8'h10: return w;
      8'h14: return {25'h0, w[6:0]};
      default: return 32'h0;
    endcase
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: response %b expected %b", $time, got, exp);
    end
  endtask

  // Bus access with the response code checked on every transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    amp_host_model_i.xfer(w, a, d, rd, err);
    cmp_resp(err, a > 8'h30);
    if (w) mdl[a] = d;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask

  task automatic go();
    @(posedge ref_clk);
    motionStart <= 1'b1;
    @(posedge ref_clk);
    motionStart <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic conclude();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog, well beyond the several hundred cycles the run needs
  initial begin
    #500000;
    failures++;
    conclude();
  end

  initial begin
    rnd = $urandom(32'he6cf);
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    for (int a = 0; a <= 8'h30; a += 4) rdchk(a[7:0], 32'h0);
    // Raw random words show discarded and sign-extended bits
    for (int i = 0; i < 4; i++) begin
      foreach (regAddr[j]) begin
        bus(1'b1, regAddr[j], $urandom);
        rdchk(regAddr[j], view(regAddr[j], mdl[regAddr[j]]));
      end
    end
    bus(1'b1, 8'h24, 32'hffffffff);
    rdchk(8'h24, 32'h0);
    bus(1'b1, 8'h34, 32'h1);
    rdchk(8'h34, 32'h0);
    // Centre working copy follows only the four interpolation kinds
    v = 32'h0;
    foreach (kinds[k]) begin
      rd = $urandom;
      bus(1'b1, 8'h00, {{4{rd[27]}}, rd[27:0]});
      bus(1'b1, 8'h14, {25'h0, kinds[k]});
      go();
      if (k < 4) v = view(8'h00, mdl[0]);
      rdchk(8'h24, v);
      cmp({4'h0, centerFeedWork}, {4'h0, v[27:0]});
      cmp({29'h0, interpUsesCenter, centerIsCircle, centerIsFeed},
        {29'h0, k < 4, k == 2 || k == 3, k < 2});
      bus(1'b0, 8'h30, 32'h0);
      cmp(rd & 32'h7, {29'h0, k < 4, k == 2 || k == 3, k < 2});
    end
    // Zero acceleration range falls back to half the speed span
    bus(1'b1, 8'h18, 32'h64);
    bus(1'b1, 8'h1c, 32'h14);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h08, 32'h7fff);
    go();
    cmp({17'h0, sAccelEff}, 32'h28);
    cmp({17'h0, sDecelEff}, 32'h7fff);
    rdchk(8'h2c, 32'h7fff);
    // Constant speed source times the scale
    bus(1'b1, 8'h0c, 32'h12c);
    bus(1'b1, 8'h20, 32'h3);
    for (int s = 0; s < 3; s++) begin
      correctionMove <= s == 1;
      homeReverse <= s == 2;
      repeat (4) @(posedge ref_clk);
      cmp(constSpeedRate, s == 0 ? 32'h3c : 32'h384);
    end
    // Direction level for the four plain formats
    for (int f = 0; f < 8; f++) begin
      bus(1'b1, 8'h10, {30'h0, f[2:1]});
      moveMinus <= f[0];
      repeat (4) @(posedge ref_clk);
      cmp({31'h0, dirOut}, {31'h0, !f[0] ^ f[2]});
    end
    // Ticks six cycles apart: fixed pulses, half duty toggles, two-line format
    for (int f = 0; f < 3; f++) begin
      bus(1'b1, 8'h10, {f == 1, 28'h0, f == 2, 2'h0});
      moveMinus <= f == 2;
      repeat (2) @(posedge ref_clk);
      v = 32'h0;
      for (int c = 0; c < 18; c++) begin
        stepTick <= c % 6 == 0;
        @(posedge ref_clk);
        v += {15'h0, dirOut, 15'h0, pulseOut};
      end
      cmp(v, f == 2 ? 32'h000c0000 : (f == 1 ? 32'h0012000a : 32'h0012000c));
    end
    // Sensor filter drops a two-cycle glitch, plain path passes a level change
    bus(1'b1, 8'h10, 32'h04000000);
    sensorPins <= 5'h15;
    repeat (12) @(posedge ref_clk);
    sensorPins <= 5'h0a;
    repeat (2) @(posedge ref_clk);
    sensorPins <= 5'h15;
    // Unfiltered, the glitch would show on the clean levels just now
    repeat (2) @(posedge ref_clk);
    cmp({27'h0, sensorsClean}, 32'h15);
    repeat (10) @(posedge ref_clk);
    bus(1'b1, 8'h10, 32'h0);
    sensorPins <= 5'h0a;
    repeat (6) @(posedge ref_clk);
    cmp({27'h0, sensorsClean}, 32'h0a);
    // Wipe modes: an edge gives one pulse, a level follows the line
    for (int m = 0; m < 4; m++) begin
      counterWipeLine <= !m[0];
      bus(1'b1, 8'h10, {10'h0, m[1:0], 20'h0});
      repeat (4) @(posedge ref_clk);
      counterWipeLine <= m[0];
      v = 32'h0;
      repeat (6) begin
        @(posedge ref_clk);
        v += {31'h0, counterWipe};
      end
      cmp(v, m[1] ? 32'h3 : 32'h1);
      cmp({31'h0, counterWipe}, {31'h0, m[1]});
    end
    // Shared start: level mode fires, edge mode stays quiet on a held line
    bus(1'b1, 8'h10, 32'h0);
    sharedStartLine_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    cmp({31'h0, sharedStartFire}, 32'h1);
    bus(1'b1, 8'h10, 32'h00040000);
    repeat (8) @(posedge ref_clk);
    cmp({31'h0, sharedStartFire}, 32'h0);
    // Edge mode gives one pulse per falling edge
    sharedStartLine_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sharedStartLine_n <= 1'b0;
    v = 32'h0;
    repeat (8) begin
      @(posedge ref_clk);
      v += {31'h0, sharedStartFire};
    end
    cmp(v, 32'h1);
    sharedStartLine_n <= 1'b1;
    // Second reset in mid-run clears the registers
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    rdchk(8'h10, 32'h0);
    rdchk(8'h08, 32'h0);
    conclude();
  end
endmodule
